// ---- rtl/supply_tuning_defines.vh ----
`ifndef SUPPLY_TUNING_DEFINES_VH
`define SUPPLY_TUNING_DEFINES_VH
// ==========================================
// Register offsets
`define OFF_SUPPLY_SELECT 8'h3a
`define OFF_BYPASS_CTRL 8'h3b
`define OFF_ACCEPT_BER 8'h46
`define OFF_ACTUAL_BER 8'h47
`define OFF_WL_SET_HI 8'h48
`define OFF_WL_SET_LO 8'h49
`define OFF_WL_ERR_HI 8'h4a
`define OFF_WL_ERR_LO 8'h4b
`define OFF_AMP_ADJ 8'h4c
`define OFF_PHASE_ADJ 8'h4d
// ==========================================
// Reset values and field constants
`define ZERO_NIBBLE 4'h0
`define ZERO_BYTE 8'h00
`define ZERO_WORD 16'h0000
`define BYPASS_BIT 0
`define MIN_LV_CODE 4'h3
`define BYPASS_CODE 4'h6
`define WL_MIN 16'h0000
`define WL_MAX 16'hffff
`define WL_TOL 16'h0014
`define NOMINAL_CODE 4'h0
// Setpoint steps are ten times coarser than error steps
`define WL_SCALE 16'h000a
`define ONE_WORD 16'h0001
`define RSVD_BITS 3'h0
`define AVAIL_ALL 2'h3
`define AVAIL_NONE 2'h0
// Lower nibble codes that mean a higher voltage are numerically smaller
`endif

// ---- rtl/supply_tuning_regs.v ----
`timescale 1ns/100ps
`include "supply_tuning_defines.vh"
module supply_tuning_regs #(
    parameter VPS_IMPLEMENTED = 1
) (
    input wire clk,
    input wire rst_n,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] addr,
    input wire [7:0] wr_data,
    output reg [7:0] rd_data,
    input wire power_down,
    input wire [15:0] measured_wavelength,
    input wire rail_low_limit_cmp,
    input wire rail_in_range_raw,
    output wire [1:0] mode_available,
    output wire variable_supply_mode,
    output wire bypass_active,
    output wire [3:0] second_supply_rail_code,
    output wire [3:0] aux_rail_threshold_code,
    output wire tx_disable,
    output wire module_not_ready_out,
    output wire interrupt_out,
    output wire rail_fault_flag,
    output wire wl_error_flag,
    output wire [7:0] acceptable_ber,
    output wire [7:0] actual_ber,
    output wire [15:0] wavelength_target,
    output wire [15:0] wavelength_error,
    output wire [7:0] amplitude_threshold,
    output wire [7:0] phase_point
);
    // ==========================================
    // Pin synchronisers
    reg pd_meta_reg;
    reg pd_sync_reg;
    reg rail_meta_reg;
    reg rail_sync_reg;
    reg pd_prev_reg;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pd_meta_reg <= 1'b1;
            pd_sync_reg <= 1'b1;
            rail_meta_reg <= 1'b0;
            rail_sync_reg <= 1'b0;
            pd_prev_reg <= 1'b1;
        end
        else
        begin
            pd_meta_reg <= power_down;
            pd_sync_reg <= pd_meta_reg;
            rail_meta_reg <= rail_in_range_raw;
            rail_sync_reg <= rail_meta_reg;
            pd_prev_reg <= pd_sync_reg;
        end
    end
    wire pd_release = pd_prev_reg & ~pd_sync_reg;

    // ==========================================
    // Writable registers
    reg [3:0] vsel_reg;
    reg bypass_reg;
    reg [7:0] accept_ber_reg;
    reg [7:0] actual_ber_reg;
    reg [15:0] wl_set_reg;
    reg [7:0] wl_hi_hold_reg;
    reg [7:0] amp_reg;
    reg [7:0] phase_reg;
    wire vps_on = (VPS_IMPLEMENTED != 0);
    // One decoded strobe per byte keeps the write side easy to audit
    wire we_vsel = wr_en & (addr == `OFF_SUPPLY_SELECT) & vps_on;
    wire we_bypass = wr_en & (addr == `OFF_BYPASS_CTRL) & vps_on;
    wire we_accept = wr_en & (addr == `OFF_ACCEPT_BER);
    wire we_actual = wr_en & (addr == `OFF_ACTUAL_BER);
    wire we_wl_hi = wr_en & (addr == `OFF_WL_SET_HI);
    wire we_wl_lo = wr_en & (addr == `OFF_WL_SET_LO);
    wire we_amp = wr_en & (addr == `OFF_AMP_ADJ);
    wire we_phase = wr_en & (addr == `OFF_PHASE_ADJ);
    // Setpoint bytes commit together on the low byte so the tuner never sees half a value
    wire [15:0] wl_raw = {wl_hi_hold_reg, wr_data};
    wire [15:0] wl_clip = (wl_raw < `WL_MIN) ? `WL_MIN : ((wl_raw > `WL_MAX) ? `WL_MAX : wl_raw);
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vsel_reg <= `ZERO_NIBBLE;
            bypass_reg <= 1'b0;
            accept_ber_reg <= `ZERO_BYTE;
            actual_ber_reg <= `ZERO_BYTE;
            wl_set_reg <= `ZERO_WORD;
            wl_hi_hold_reg <= `ZERO_BYTE;
            amp_reg <= `ZERO_BYTE;
            phase_reg <= `ZERO_BYTE;
        end
        else
        begin
            // Power-down release does not touch these; only writes and reset do
            if (we_vsel)
                vsel_reg <= wr_data[3:0];
            if (we_bypass)
                bypass_reg <= wr_data[`BYPASS_BIT];
            if (we_accept)
                accept_ber_reg <= wr_data;
            if (we_actual)
                actual_ber_reg <= wr_data;
            if (we_wl_hi)
                wl_hi_hold_reg <= wr_data;
            if (we_wl_lo)
                wl_set_reg <= wl_clip;
            if (we_amp)
                amp_reg <= wr_data;
            if (we_phase)
                phase_reg <= wr_data;
        end
    end

    // ==========================================
    // Mode and rail supervision
    assign variable_supply_mode = vps_on & (vsel_reg != `NOMINAL_CODE);
    assign bypass_active = vps_on & bypass_reg & (vsel_reg == `NOMINAL_CODE);
    assign second_supply_rail_code = variable_supply_mode ? vsel_reg :
        (bypass_active ? `BYPASS_CODE : `NOMINAL_CODE);
    // Lower alarm limit follows the chosen mode without host rewrite
    assign aux_rail_threshold_code = second_supply_rail_code;
    assign mode_available = vps_on ? `AVAIL_ALL : `AVAIL_NONE;

    reg rail_fault_reg;
    reg not_ready_reg;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rail_fault_reg <= 1'b0;
            not_ready_reg <= 1'b1;
        end
        else
        begin
            // Set beats the read-clear in the same cycle
            if ((pd_release & ~rail_sync_reg) | (~pd_sync_reg & ~rail_sync_reg & vps_on))
                rail_fault_reg <= 1'b1;
            else if (rd_en && addr == `OFF_SUPPLY_SELECT)
                rail_fault_reg <= 1'b0;
            if (pd_sync_reg)
                not_ready_reg <= 1'b1;
            else if (pd_release)
                not_ready_reg <= ~rail_sync_reg;
        end
    end
    assign rail_fault_flag = rail_fault_reg;
    assign module_not_ready_out = not_ready_reg;
    assign tx_disable = pd_sync_reg | not_ready_reg;

    // ==========================================
    // Wavelength error monitor
    reg [15:0] wl_err_reg;
    reg [7:0] wl_err_lo_hold_reg;
    reg wl_flag_reg;
    wire [15:0] wl_diff = measured_wavelength - (wl_set_reg * `WL_SCALE);
    wire [15:0] wl_abs = wl_diff[15] ? (~wl_diff + `ONE_WORD) : wl_diff;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wl_err_reg <= `ZERO_WORD;
            wl_err_lo_hold_reg <= `ZERO_BYTE;
            wl_flag_reg <= 1'b0;
        end
        else
        begin
            // Low byte frozen at the high-byte read so a two-byte read stays coherent
            if (rd_en && addr == `OFF_WL_ERR_HI)
                wl_err_lo_hold_reg <= wl_err_reg[7:0];
            else
                wl_err_reg <= wl_diff;
            if (wl_abs > `WL_TOL)
                wl_flag_reg <= 1'b1;
            else if (rd_en && addr == `OFF_WL_ERR_LO)
                wl_flag_reg <= 1'b0;
        end
    end
    assign wl_error_flag = wl_flag_reg;
    assign interrupt_out = rail_fault_reg | wl_flag_reg;

    // ==========================================
    // Read mux
    // Unmapped addresses read zero so a host probing for options sees nothing
    reg [7:0] rd_data_next;
    always @*
    begin
        rd_data_next = `ZERO_BYTE;
        if (addr == `OFF_SUPPLY_SELECT)
        begin
            rd_data_next = vps_on ? {`MIN_LV_CODE, vsel_reg} : `ZERO_BYTE;
        end
        else if (addr == `OFF_BYPASS_CTRL)
        begin
            rd_data_next = vps_on ? {`BYPASS_CODE, `RSVD_BITS, bypass_reg} : `ZERO_BYTE;
        end
        else if (addr == `OFF_ACCEPT_BER)
        begin
            rd_data_next = accept_ber_reg;
        end
        else if (addr == `OFF_ACTUAL_BER)
        begin
            rd_data_next = actual_ber_reg;
        end
        else if (addr == `OFF_WL_SET_HI)
        begin
            rd_data_next = wl_set_reg[15:8];
        end
        else if (addr == `OFF_WL_SET_LO)
        begin
            rd_data_next = wl_set_reg[7:0];
        end
        else if (addr == `OFF_WL_ERR_HI)
        begin
            rd_data_next = wl_err_reg[15:8];
        end
        else if (addr == `OFF_WL_ERR_LO)
        begin
            rd_data_next = wl_err_lo_hold_reg;
        end
        else if (addr == `OFF_AMP_ADJ)
        begin
            rd_data_next = amp_reg;
        end
        else if (addr == `OFF_PHASE_ADJ)
        begin
            rd_data_next = phase_reg;
        end
    end

    // Data stands until the next read strobe
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_data <= `ZERO_BYTE;
        else if (rd_en)
            rd_data <= rd_data_next;
    end

    assign acceptable_ber = accept_ber_reg;
    assign actual_ber = actual_ber_reg;
    assign wavelength_target = wl_set_reg;
    assign wavelength_error = wl_err_reg;
    assign amplitude_threshold = amp_reg;
    assign phase_point = phase_reg;
    wire unused_cmp = rail_low_limit_cmp;
endmodule // supply_tuning_regs

// ---- verification/supply_tuning_regs_assertions.sv ----
`timescale 1ns/100ps
`include "supply_tuning_defines.vh"
// ==========================================
// Port checks
module supply_tuning_regs_assertions (
    input wire clk,
    input wire rst_n,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] addr,
    input wire [7:0] wr_data,
    input wire [7:0] rd_data,
    input wire power_down,
    input wire [1:0] mode_available,
    input wire variable_supply_mode,
    input wire bypass_active,
    input wire tx_disable,
    input wire interrupt_out,
    input wire rail_fault_flag,
    input wire wl_error_flag,
    input wire [7:0] amplitude_threshold
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_lv_floor; rd_en && addr == `OFF_SUPPLY_SELECT |=> rd_data[7:4] == `MIN_LV_CODE; endproperty
    a_lv_floor: assert property (p_lv_floor) else $error("Supply floor code wrong");
    property p_byp_code; rd_en && addr == `OFF_BYPASS_CTRL |=> rd_data[7:4] == `BYPASS_CODE; endproperty
    a_byp_code: assert property (p_byp_code) else $error("Bypass code wrong");
    property p_lv_sel; wr_en && addr == `OFF_SUPPLY_SELECT |=> variable_supply_mode == |($past(wr_data) & 8'h0f); endproperty
    a_lv_sel: assert property (p_lv_sel) else $error("Low voltage mode not following nibble");
    property p_override; variable_supply_mode |-> !bypass_active; endproperty
    a_override: assert property (p_override) else $error("Bypass active with nibble set");
    property p_avail; mode_available == 2'b11; endproperty
    a_avail: assert property (p_avail) else $error("Mode availability wrong");
    property p_tx_off; power_down [*3] |-> tx_disable; endproperty
    a_tx_off: assert property (p_tx_off) else $error("Transmitter on in standby");
    property p_irq; interrupt_out == (rail_fault_flag || wl_error_flag); endproperty
    a_irq: assert property (p_irq) else $error("Interrupt not tied to flags");
    property p_amp; wr_en && addr == `OFF_AMP_ADJ |=> amplitude_threshold == $past(wr_data); endproperty
    a_amp: assert property (p_amp) else $error("Amplitude byte not taken");
    // Guards against a register that drifts without a write
    property p_hold; !(wr_en && addr == `OFF_AMP_ADJ) |=> $stable(amplitude_threshold); endproperty
    a_hold: assert property (p_hold) else $error("Amplitude byte changed unwritten");
endmodule // supply_tuning_regs_assertions
bind supply_tuning_regs supply_tuning_regs_assertions u_chk (.clk(clk), .rst_n(rst_n), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .power_down(power_down),
    .mode_available(mode_available), .variable_supply_mode(variable_supply_mode), .bypass_active(bypass_active),
    .tx_disable(tx_disable), .interrupt_out(interrupt_out), .rail_fault_flag(rail_fault_flag),
    .wl_error_flag(wl_error_flag), .amplitude_threshold(amplitude_threshold));

// ---- verification/supply_rail_model.sv ----
`timescale 1ns/100ps
`include "supply_tuning_defines.vh"
// ==========================================
// Second supply rail source
module supply_rail_model (
    input wire [3:0] applied_code,
    input wire [3:0] select_code,
    input wire lv_mode,
    input wire bypass_mode,
    output wire rail_in_range
);
    // A larger code is a lower rail, so the floor is an upper bound on the code
    assign rail_in_range = lv_mode ? (applied_code == select_code && applied_code <= `MIN_LV_CODE) :
        bypass_mode ? (applied_code == `BYPASS_CODE) : (applied_code == `NOMINAL_CODE);
endmodule // supply_rail_model

// ---- verification/module_supply_tuning_fec_regs_tb.sv ----
`timescale 1ns/100ps
`include "supply_tuning_defines.vh"
module module_supply_tuning_fec_regs_tb;
    reg clk;
    reg rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, power_down = 1'b1;
    reg [7:0] addr = 8'h00, wr_data = 8'h00, a;
    reg [15:0] measured_wavelength = 16'h0000, sp;
    reg [3:0] applied_code = 4'h0;
    reg [31:0] seed = 32'hc7f3_09c7;
    wire [7:0] rd_data, acceptable_ber, actual_ber, amplitude_threshold, phase_point;
    wire [15:0] wavelength_target, wavelength_error;
    wire [3:0] rail_code, thr_code;
    wire [1:0] mode_available;
    wire rail_ok, variable_supply_mode, bypass_active, tx_disable, module_not_ready_out;
    wire interrupt_out, rail_fault_flag, wl_error_flag;
    integer n_mismatch = 0, n_compared = 0, i, e;
    integer exp_mem [0:255];
    supply_tuning_regs u_dut (.clk(clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wr_data(wr_data), .rd_data(rd_data), .power_down(power_down), .measured_wavelength(measured_wavelength),
        .rail_low_limit_cmp(1'b0), .rail_in_range_raw(rail_ok), .mode_available(mode_available),
        .variable_supply_mode(variable_supply_mode), .bypass_active(bypass_active),
        .second_supply_rail_code(rail_code), .aux_rail_threshold_code(thr_code), .tx_disable(tx_disable),
        .module_not_ready_out(module_not_ready_out), .interrupt_out(interrupt_out),
        .rail_fault_flag(rail_fault_flag), .wl_error_flag(wl_error_flag), .acceptable_ber(acceptable_ber),
        .actual_ber(actual_ber), .wavelength_target(wavelength_target), .wavelength_error(wavelength_error),
        .amplitude_threshold(amplitude_threshold), .phase_point(phase_point));
    supply_rail_model u_rail (.applied_code(applied_code), .select_code(rail_code),
        .lv_mode(variable_supply_mode), .bypass_mode(bypass_active), .rail_in_range(rail_ok));
    // ==========================================
    // Bus tasks and checks
    function [31:0] xs(input [31:0] s);
    begin
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        xs = s ^ (s << 5);
    end
    endfunction
    task chk(input [15:0] got, input [15:0] exp);
    begin
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task wr(input [7:0] ad, input [7:0] d);
    begin
        @(posedge clk);
        wr_en <= 1'b1; addr <= ad; wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    end
    endtask
    // Read data lands at the taking edge, so it is sampled just after it
    task rd(input [7:0] ad, input [7:0] exp);
    begin
        @(posedge clk);
        rd_en <= 1'b1; addr <= ad;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk({8'h00, rd_data}, {8'h00, exp});
    end
    endtask
    task wrap_up;
    begin
        $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch = n_mismatch + 1;
        wrap_up;
    end
    // ==========================================
    // Scenarios
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(`OFF_SUPPLY_SELECT, {`MIN_LV_CODE, 4'h0});
        rd(`OFF_BYPASS_CTRL, {`BYPASS_CODE, 4'h0});
        chk(mode_available, 2'b11);
        $display("Reset values done");
        for (i = 0; i < 12; i = i + 1)
        begin
            seed = xs(seed);
            a = (i % 4 < 2) ? 8'h46 + i % 4 : 8'h4a + i % 4;
            exp_mem[a] = seed[7:0];
            wr(a, seed[7:0]);
        end
        for (i = 0; i < 4; i = i + 1)
            rd((i < 2) ? 8'h46 + i : 8'h4a + i, exp_mem[(i < 2) ? 8'h46 + i : 8'h4a + i]);
        chk({acceptable_ber, actual_ber}, {exp_mem[70][7:0], exp_mem[71][7:0]});
        chk({amplitude_threshold, phase_point}, {exp_mem[76][7:0], exp_mem[77][7:0]});
        $display("Plain bytes done");
        for (i = 0; i < 2; i = i + 1)
        begin
            seed = xs(seed);
            sp = {4'h0, seed[11:0]};
            e = (i == 0) ? 3 : -64;
            wr(`OFF_WL_SET_HI, sp[15:8]);
            wr(`OFF_WL_SET_LO, sp[7:0]);
            measured_wavelength <= sp * 10 + e;
            repeat (2) @(posedge clk);
            chk(wavelength_target, sp);
            chk(wavelength_error, e);
            rd(`OFF_WL_ERR_HI, e >> 8);
            rd(`OFF_WL_ERR_LO, e & 255);
            repeat (2) @(posedge clk);
            chk({wl_error_flag, interrupt_out}, {2{e < -20}});
        end
        $display("Wavelength done");
        applied_code <= 4'h2;
        wr(`OFF_SUPPLY_SELECT, 8'h02);
        power_down <= 1'b0;
        repeat (6) @(posedge clk);
        chk({module_not_ready_out, tx_disable, variable_supply_mode}, 3'b001);
        chk(thr_code, 4'h2);
        rd(`OFF_SUPPLY_SELECT, {`MIN_LV_CODE, 4'h2});
        power_down <= 1'b1;
        wr(`OFF_SUPPLY_SELECT, 8'h00);
        wr(`OFF_BYPASS_CTRL, 8'h01);
        applied_code <= 4'h3;
        power_down <= 1'b0;
        repeat (6) @(posedge clk);
        chk({module_not_ready_out, rail_fault_flag, interrupt_out, bypass_active}, 4'hf);
        power_down <= 1'b1;
        wr(`OFF_SUPPLY_SELECT, 8'h04);
        #1 chk({variable_supply_mode, bypass_active}, 2'b10);
        rd(`OFF_BYPASS_CTRL, {`BYPASS_CODE, 4'h1});
        rd(8'h60, 8'h00);
        $display("Supply modes done");
        wrap_up;
    end
endmodule // module_supply_tuning_fec_regs_tb
